// ===== rtl/hpm_pkg.sv
package hpm_pkg;
    // Host interface selection, as caught from the strap.
    typedef enum logic {
        HPM_IF_WIRE = 1'b0,
        HPM_IF_SPI  = 1'b1
    } hpm_if_t;

    // Zero-cross output behaviours selected by the two mode bits.
    typedef enum logic [1:0] {
        HPM_ZX_RISE = 2'h0,
        HPM_ZX_FALL = 2'h1,
        HPM_ZX_BOTH = 2'h2,
        HPM_ZX_LVL  = 2'h3
    } hpm_zxmode_t;

    // Field positions in the metering control word.
    localparam int unsigned HPM_ZXCFG_BIT = 7;
    localparam int unsigned HPM_ZERO_CROSS_MODE_LO_BIT  = 8;
    localparam int unsigned HPM_ZERO_CROSS_MODE_HI_BIT  = 9;
    localparam int unsigned HPM_CTRL_W    = 16;

    // Reset values.
    localparam logic [15:0] HPM_CTRL_RST  = 16'h0000;
    localparam logic        HPM_PULSE_RST = 1'b0;
    localparam logic        HPM_SHARE_RST = 1'b1;
    localparam logic        HPM_RFLAG_RST = 1'b0;

    // Zero-cross edge-mode output pulse width, in time and in cycles.
    localparam int unsigned HPM_CLK_HZ      = 10_000_000;
    localparam int unsigned HPM_ZX_PULSE_NS = 1000;
    localparam int unsigned HPM_ZX_PULSE_CYC =
        (HPM_ZX_PULSE_NS * (HPM_CLK_HZ / 1_000_000) + 999) / 1000;
endpackage

// ===== rtl/hpm_link_if.sv
`timescale 1ns/10ps
// Zero-cross, interrupt and reset-sign levels handed from the top to the output mux.
interface hpm_link_if;
    logic zxRaw;
    logic irqLow;
    logic resetSign;
    logic shareOut;
    modport top (output zxRaw, output irqLow, output resetSign, input shareOut);
    modport mux (input zxRaw, input irqLow, input resetSign, output shareOut);
endinterface

// ===== rtl/hpm_share_mux.sv
`timescale 1ns/10ps
// Picks the role of the shared interrupt, zero-cross and reset-sign pin.
module hpm_share_mux
    import hpm_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire hpm_if_t               ifSel,
    input  wire logic [HPM_CTRL_W-1:0] ctrl,
    hpm_link_if.mux                    lnk
);
    logic        zxPrev_ff;
    logic        zxEvt;
    logic [7:0]  zxCnt_ff;
    logic [7:0]  nxt_zxCnt;
    logic        zxOut;
    hpm_zxmode_t zxMode;

    assign zxMode = hpm_zxmode_t'({ctrl[HPM_ZERO_CROSS_MODE_HI_BIT], ctrl[HPM_ZERO_CROSS_MODE_LO_BIT]}); // R14

    // Edge detector on the already synchronised zero-cross level.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            zxPrev_ff <= 1'b0;
        end else begin
            zxPrev_ff <= lnk.zxRaw;
        end
    end

    // Edge kind picked by the mode bits.
    always_comb begin
        unique case (zxMode) // R14
            HPM_ZX_RISE: zxEvt = lnk.zxRaw & ~zxPrev_ff;
            HPM_ZX_FALL: zxEvt = ~lnk.zxRaw & zxPrev_ff;
            HPM_ZX_BOTH: zxEvt = lnk.zxRaw ^ zxPrev_ff;
            HPM_ZX_LVL:  zxEvt = 1'b0;
        endcase
    end

    // Stretch each edge so a slow host can see it.
    always_comb begin
        nxt_zxCnt = zxCnt_ff;
        if (zxEvt) begin
            nxt_zxCnt = 8'(HPM_ZX_PULSE_CYC);
        end else if (zxCnt_ff != 8'h00) begin
            nxt_zxCnt = zxCnt_ff - 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            zxCnt_ff <= 8'h00;
        end else begin
            zxCnt_ff <= nxt_zxCnt;
        end
    end

    // Level mode passes the comparator straight; edge modes give a pulse.
    assign zxOut = (zxMode == HPM_ZX_LVL) ? lnk.zxRaw : (zxCnt_ff != 8'h00); // R14

    // Role of the shared pin.
    always_comb begin
        if (ctrl[HPM_ZXCFG_BIT]) begin
            lnk.shareOut = zxOut; // R9
        end else if (ifSel == HPM_IF_SPI) begin
            lnk.shareOut = lnk.irqLow; // R7
        end else begin
            lnk.shareOut = lnk.resetSign; // R8
        end
    end
endmodule

// ===== rtl/hpm_host_pin_mux.sv
`timescale 1ns/10ps
// How it works
// R1: A low strap picks the single-wire link and a high strap picks the SPI port.
// R2: In SPI mode the shared data pin is the serial output and floats after reset.
// R3: In single-wire mode the data pin is an input, driven only during a response.
// R4: In SPI mode serial data and clock are taken from their input pins.
// R5: In SPI mode a low chip select selects the device; otherwise it is unused.
// R6: After reset the shared output pin rests high and first carries the reset sign, the interrupt only once an SPI strap is caught.
// R7: With zero-cross off and SPI chosen the pin carries the low interrupt request.
// R8: With zero-cross off and the link chosen the pin carries the reset sign.
// R9: With zero-cross on the pin carries the zero-crossing output in either mode.
// R10: The active energy pulse rests low and follows the active power.
// R11: The reactive energy pulse rests low and follows the reactive power.
// R12: The block is held in reset while the reset pin is low.
// R13: A reset flag sets when reset ends and clears when status is read.
// R14: Two mode bits choose one of four zero-crossing output behaviours.
// R15: The strap is caught at reset release and held until the next reset.
module hpm_host_pin_mux
    import hpm_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  interfaceSelectStrap,
    input  wire logic [HPM_CTRL_W-1:0] meteringControl,
    input  wire logic                  dataPinIn,
    input  wire logic                  serialDataIn,
    input  wire logic                  serialClkIn,
    input  wire logic                  chipSelectLow,
    input  wire logic                  coreTxData,
    input  wire logic                  coreTxEn,
    input  wire logic                  coreIrqLow,
    input  wire logic                  coreZeroCross,
    input  wire logic                  coreActivePulse,
    input  wire logic                  coreReactivePulse,
    input  wire logic                  statusRead,
    output logic                       dataPinOut_ff,
    output logic                       dataPinOe_ff,
    output logic                       spiSelected_ff,
    output logic                       spiData_ff,
    output logic                       spiClk_ff,
    output logic                       spiSelect_ff,
    output logic                       wireData_ff,
    output logic                       shareOut_ff,
    output logic                       activeEnergyPulse_ff,
    output logic                       reactiveEnergyPulse_ff,
    output logic                       resetFlag_ff
);
    hpm_link_if lnk ();

    logic    strapS1_ff;
    logic    strapS2_ff;
    logic    dataS1_ff;
    logic    dataS2_ff;
    logic    sdiS1_ff;
    logic    sdiS2_ff;
    logic    sclkS1_ff;
    logic    sclkS2_ff;
    logic    csS1_ff;
    logic    csS2_ff;
    logic    zxS1_ff;
    logic    zxS2_ff;
    logic    strapTaken_ff;
    hpm_if_t ifSel_ff;
    logic    justOut_ff;
    logic    strapReady_ff;
    logic    isSpi;

    // Every pin-side input passes two flops before anything reads it.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strapS1_ff <= 1'b0;
            strapS2_ff <= 1'b0;
            dataS1_ff  <= 1'b1;
            dataS2_ff  <= 1'b1;
            sdiS1_ff   <= 1'b1;
            sdiS2_ff   <= 1'b1;
            sclkS1_ff  <= 1'b1;
            sclkS2_ff  <= 1'b1;
            csS1_ff    <= 1'b1;
            csS2_ff    <= 1'b1;
            zxS1_ff    <= 1'b0;
            zxS2_ff    <= 1'b0;
        end else begin
            strapS1_ff <= interfaceSelectStrap;
            strapS2_ff <= strapS1_ff;
            dataS1_ff  <= dataPinIn;
            dataS2_ff  <= dataS1_ff;
            sdiS1_ff   <= serialDataIn;
            sdiS2_ff   <= sdiS1_ff;
            sclkS1_ff  <= serialClkIn;
            sclkS2_ff  <= sclkS1_ff;
            csS1_ff    <= chipSelectLow;
            csS2_ff    <= csS1_ff;
            zxS1_ff    <= coreZeroCross;
            zxS2_ff    <= zxS1_ff;
        end
    end

    // The strap is caught once after release and then frozen; a strap that
    // moves later cannot swap pin roles under a live host.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin // R12
            strapTaken_ff <= 1'b0;
            ifSel_ff      <= HPM_IF_WIRE;
        end else if (strapTaken_ff == 1'b0 && strapReady_ff) begin
            strapTaken_ff <= 1'b1; // R15
            ifSel_ff      <= hpm_if_t'(strapS2_ff); // R1
        end
    end

    // Counts the synchroniser fill so the strap is read only once it is valid.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            justOut_ff <= 1'b0;
        end else begin
            justOut_ff <= strapS1_ff | ~strapS1_ff;
        end
    end

    // The second stage still holds its reset value one edge after release, so
    // the capture waits one more edge until the strap has reached it.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strapReady_ff <= 1'b0;
        end else begin
            strapReady_ff <= justOut_ff;
        end
    end

    assign isSpi = strapTaken_ff && (ifSel_ff == HPM_IF_SPI);

    // Data pin direction and value; nothing drives it until a mode is known.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dataPinOut_ff <= 1'b1;
            dataPinOe_ff  <= 1'b0; // R2
        end else if (isSpi) begin
            dataPinOut_ff <= coreTxData; // R2
            dataPinOe_ff  <= coreTxEn & ~csS2_ff; // R5
        end else begin
            dataPinOut_ff <= coreTxData;
            dataPinOe_ff  <= strapTaken_ff & coreTxEn; // R3
        end
    end

    // Inputs handed to the serial engines; unused side rests idle high.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            spiSelected_ff <= 1'b0;
            spiData_ff     <= 1'b1;
            spiClk_ff      <= 1'b1;
            spiSelect_ff   <= 1'b1;
            wireData_ff    <= 1'b1;
        end else begin
            spiSelected_ff <= isSpi; // R1
            spiData_ff     <= isSpi ? sdiS2_ff : 1'b1; // R4
            spiClk_ff      <= isSpi ? sclkS2_ff : 1'b1; // R4
            spiSelect_ff   <= isSpi ? csS2_ff : 1'b1; // R5
            wireData_ff    <= isSpi ? 1'b1 : dataS2_ff; // R3
        end
    end

    // Reset flag: the read clears it, but setting wins in the same cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            resetFlag_ff <= HPM_RFLAG_RST;
        end else if (justOut_ff == 1'b0) begin
            resetFlag_ff <= 1'b1; // R13
        end else if (statusRead) begin
            resetFlag_ff <= 1'b0; // R13
        end
    end

    assign lnk.zxRaw     = zxS2_ff;
    assign lnk.irqLow    = coreIrqLow;
    assign lnk.resetSign = resetFlag_ff;

    hpm_share_mux u_share (
        .mclk  (mclk),
        .rstn  (rstn),
        .ifSel (isSpi ? HPM_IF_SPI : HPM_IF_WIRE),
        .ctrl  (meteringControl),
        .lnk   (lnk.mux)
    );

    // Shared pin and energy pulses, all registered; idle levels from reset.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shareOut_ff            <= HPM_SHARE_RST; // R6
            activeEnergyPulse_ff   <= HPM_PULSE_RST; // R10
            reactiveEnergyPulse_ff <= HPM_PULSE_RST; // R11
        end else begin
            shareOut_ff            <= lnk.shareOut; // R6
            activeEnergyPulse_ff   <= coreActivePulse; // R10
            reactiveEnergyPulse_ff <= coreReactivePulse; // R11
        end
    end
endmodule

// ===== tb/hpm_host_model.sv
`timescale 1ns/10ps
// Serial host: runs an SPI transfer while busy and leaves the data pin to its pull-up.
module hpm_host_model (
    input  wire logic mclk,
    input  wire logic busy,
    input  wire logic dataPinOut_ff,
    input  wire logic dataPinOe_ff,
    output logic      chipSelectLow,
    output logic      serialDataIn,
    output logic      serialClkIn,
    output logic      dataPinIn
);
    // Lines start idle so the block never samples an unknown pin.
    initial {chipSelectLow, serialDataIn, serialClkIn} = 3'h7;

    // Select stays low for the whole transfer; the data line changes every cycle.
    always @(posedge mclk) begin
        chipSelectLow <= #5 !busy;
        serialClkIn   <= #5 busy ? !serialClkIn : 1'b1;
        serialDataIn  <= #5 busy ? !serialDataIn : 1'b1;
    end

    // The pull-up wins whenever the block does not drive.
    assign dataPinIn = dataPinOe_ff ? dataPinOut_ff : 1'b1;
endmodule

// ===== tb/hpm_host_pin_mux_properties.sv
`timescale 1ns/10ps
// Port-level checks of the pin mux.
module hpm_pin_mux_props
    import hpm_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  rstn,
    input wire logic [HPM_CTRL_W-1:0] meteringControl,
    input wire logic                  serialDataIn,
    input wire logic                  serialClkIn,
    input wire logic                  chipSelectLow,
    input wire logic                  dataPinIn,
    input wire logic                  spiData_ff,
    input wire logic                  spiClk_ff,
    input wire logic                  spiSelect_ff,
    input wire logic                  wireData_ff,
    input wire logic                  coreTxData,
    input wire logic                  coreTxEn,
    input wire logic                  coreIrqLow,
    input wire logic                  coreActivePulse,
    input wire logic                  coreReactivePulse,
    input wire logic                  statusRead,
    input wire logic                  dataPinOut_ff,
    input wire logic                  dataPinOe_ff,
    input wire logic                  spiSelected_ff,
    input wire logic                  shareOut_ff,
    input wire logic                  activeEnergyPulse_ff,
    input wire logic                  reactiveEnergyPulse_ff,
    input wire logic                  resetFlag_ff
);
    logic [2:0] upCnt_ff;
    wire        up = upCnt_ff == 3'h5;

    // Mode checks wait five edges, since the mode shows only at the fourth.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            upCnt_ff <= 3'h0;
        end else if (!up) begin
            upCnt_ff <= upCnt_ff + 3'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    tx_wire_a: assert property (
        up && !spiSelected_ff && coreTxEn |=> dataPinOe_ff && dataPinOut_ff == $past(coreTxData))
        else $error("Link reply not driven.");
    oe_cause_a: assert property ($rose(dataPinOe_ff) |-> $past(coreTxEn))
        else $error("Data pin driven unasked.");
    mode_hold_a: assert property (up && $past(up) |-> $stable(spiSelected_ff))
        else $error("Interface mode changed.");
    irq_route_a: assert property (
        up && spiSelected_ff && !meteringControl[HPM_ZXCFG_BIT] |=>
        shareOut_ff == $past(coreIrqLow))
        else $error("Interrupt not routed.");
    sign_route_a: assert property (
        up && !spiSelected_ff && !meteringControl[HPM_ZXCFG_BIT] |=>
        shareOut_ff == $past(resetFlag_ff))
        else $error("Reset sign not routed.");
    spi_tx_a: assert property (
        up && spiSelected_ff && coreTxEn |=> dataPinOe_ff && dataPinOut_ff == $past(coreTxData))
        else $error("SPI reply not driven.");
    spi_pass_a: assert property (up && spiSelected_ff |->
        spiData_ff == $past(serialDataIn, 3) && spiClk_ff == $past(serialClkIn, 3)
        && spiSelect_ff == $past(chipSelectLow, 3) && wireData_ff)
        else $error("SPI pins not passed.");
    wire_pass_a: assert property (up && !spiSelected_ff |->
        wireData_ff == $past(dataPinIn, 3) && spiData_ff && spiClk_ff && spiSelect_ff)
        else $error("Link pin not passed.");
    pulse_out_a: assert property (1'b1 |=> activeEnergyPulse_ff == $past(coreActivePulse)
        && reactiveEnergyPulse_ff == $past(coreReactivePulse)) else $error("Pulse mismatch.");
    flag_clear_a: assert property (up && statusRead |=> !resetFlag_ff)
        else $error("Flag not cleared.");
    rst_hold_a: assert property (disable iff (1'b0) !rstn |->
        !dataPinOe_ff && shareOut_ff && !resetFlag_ff) else $error("Reset not held.");

    cover property (up && spiSelected_ff && dataPinOe_ff);
    cover property (up && meteringControl[HPM_ZXCFG_BIT] && shareOut_ff);
    cover property (statusRead && resetFlag_ff);
endmodule

bind hpm_host_pin_mux hpm_pin_mux_props u_props (.mclk, .rstn, .meteringControl,
    .serialDataIn, .serialClkIn, .chipSelectLow, .dataPinIn, .spiData_ff, .spiClk_ff,
    .spiSelect_ff, .wireData_ff, .coreTxData,
    .coreTxEn, .coreIrqLow, .coreActivePulse, .coreReactivePulse, .statusRead, .dataPinOut_ff,
    .dataPinOe_ff, .spiSelected_ff, .shareOut_ff, .activeEnergyPulse_ff,
    .reactiveEnergyPulse_ff, .resetFlag_ff);

// ===== tb/hpm_host_pin_mux_tb_top.sv
`timescale 1ns/10ps
// Random pin traffic in both host modes, checked through a queue of due results.
module hpm_host_pin_mux_tb_top
    import hpm_pkg::*;
;
    typedef struct {int due; logic [5:0] val; logic [5:0] mask;} hpm_note_t;
    logic                  mclk = 1'b0, rstn = 1'b1, busy, flagExp, interfaceSelectStrap;
    logic                  coreTxData, coreTxEn, coreIrqLow, coreZeroCross, statusRead;
    logic                  coreActivePulse, coreReactivePulse, dataPinIn, chipSelectLow;
    logic                  serialDataIn, serialClkIn, dataPinOut_ff, dataPinOe_ff;
    logic                  spiSelected_ff, shareOut_ff, activeEnergyPulse_ff;
    logic                  reactiveEnergyPulse_ff, resetFlag_ff;
    logic [5:0]            got;
    logic [HPM_CTRL_W-1:0] meteringControl;
    hpm_note_t             notes[$];
    int                    failures = 0, comparisons = 0, cyc = 0, seed = 26579;

    hpm_host_pin_mux DUT (.mclk, .rstn, .interfaceSelectStrap, .meteringControl, .dataPinIn,
        .serialDataIn, .serialClkIn, .chipSelectLow, .coreTxData, .coreTxEn, .coreIrqLow,
        .coreZeroCross, .coreActivePulse, .coreReactivePulse, .statusRead, .dataPinOut_ff,
        .dataPinOe_ff, .spiSelected_ff, .spiData_ff(), .spiClk_ff(), .spiSelect_ff(),
        .wireData_ff(), .shareOut_ff, .activeEnergyPulse_ff, .reactiveEnergyPulse_ff,
        .resetFlag_ff);
    hpm_host_model u_host (.mclk, .busy, .dataPinOut_ff, .dataPinOe_ff, .chipSelectLow,
        .serialDataIn, .serialClkIn, .dataPinIn);

    always #50 mclk = !mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic stop_test();
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Queues a result that falls due a given number of edges from now.
    task automatic note(input int dly, input logic [5:0] v, input logic [5:0] m);
        notes.push_back('{cyc + dly, v, m});
    endtask

    // Restarts the block; the strap flips once caught, which must change nothing.
    task automatic restart(input logic s);
        rstn = 1'b0;
        interfaceSelectStrap = s;
        busy = s;
        {coreTxEn, coreTxData, coreActivePulse, coreReactivePulse, statusRead} = 5'h00;
        {coreZeroCross, coreIrqLow, meteringControl} = {2'h1, 16'h0000};
        repeat (4) @(posedge mclk);
        #5 rstn = 1'b1;
        repeat (4) @(posedge mclk);
        #5 interfaceSelectStrap = !s;
        flagExp = 1'b1;
        note(1, {1'b0, s, 1'b1, 3'h1}, 6'h3f);
        @(posedge mclk);
        #5;
    endtask

    // Moves the comparator; edge modes give a pulse shorter than twenty cycles.
    task automatic zx_to(input logic lvl, input logic early, input logic late);
        coreZeroCross = lvl;
        note(6, {2'h0, early, 3'h0}, 6'h08);
        note(20, {2'h0, late, 3'h0}, 6'h08);
        repeat (20) @(posedge mclk);
        #5;
    endtask

    // Compares every note that has fallen due with the settled outputs.
    always @(posedge mclk) begin
        #5;
        while (notes.size() != 0 && notes[0].due <= cyc) begin
            got = {dataPinOe_ff, spiSelected_ff, shareOut_ff, activeEnergyPulse_ff,
                reactiveEnergyPulse_ff, resetFlag_ff} & notes[0].mask;
            comparisons++;
            if (got !== (notes[0].val & notes[0].mask)) begin
                failures++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                    notes[0].val & notes[0].mask);
            end
            void'(notes.pop_front());
        end
    end

    // Cuts a hang short well past the expected run of under five hundred cycles.
    initial begin
        #200_000;
        failures++;
        stop_test();
    end

    initial begin
        #5;
        for (int i = 0; i < 2; i++) begin
            restart(i[0]);
            repeat (40) begin
                {coreTxEn, coreTxData, coreIrqLow, coreActivePulse, coreReactivePulse,
                    statusRead} = 6'($random(seed));
                note(1, {coreTxEn, i[0], i[0] ? coreIrqLow : flagExp, coreActivePulse,
                    coreReactivePulse, flagExp & !statusRead}, 6'h3f);
                flagExp = flagExp & !statusRead;
                @(posedge mclk);
                #5;
            end
            {coreTxEn, coreTxData, coreActivePulse, coreReactivePulse, statusRead} = 5'h00;
            for (int z = 0; z < 4; z++) begin
                meteringControl = {6'h00, z[1:0], 1'b1, 7'h00};
                zx_to(1'b1, z != 1, z == 3);
                zx_to(1'b0, z == 1 || z == 2, 1'b0);
            end
        end
        repeat (2) @(posedge mclk);
        stop_test();
    end
endmodule
